// file: hdl/hub_cfg_map.svh
`ifndef HUB_CFG_MAP_SVH
`define HUB_CFG_MAP_SVH
// image layout
`define IMG_MARKER 8'hD4
`define B_MARK 16'h0000
`define B_FIRST 16'h0007
`define B_FILTER 5'd7
`define B_FS_DEMAND 5'd8
`define B_HS_DEMAND 5'd9
`define B_CC_FSB 5'd12
`define B_CC_HSB 5'd13
`define B_CC_FSS 5'd14
`define B_CC_HSS 5'd15
`define B_PG_DELAY 5'd16
`define B_HUBCFG 5'd17
`define B_PINCFG 5'd18
`define B_WPROT 5'd19
`define B_LANGS 5'd20
`define B_STRMASK 5'd21
`define B_USABLE 5'd22
`define B_DETACH 5'd23
`define B_LAST 16'h0017
`define LANG_BASE 16'h0018
// defaults
`define DEF_FILTER 8'h88
`define DEF_FS_DEMAND 8'h28
`define DEF_HS_DEMAND 8'h57
`define DEF_CC_FS 8'h50
`define DEF_CC_HSB 8'hAE
`define DEF_CC_HSS 8'h64
`define DEF_PG_DELAY 8'h32
`define DEF_HUBCFG 8'h80
`define DEF_PINCFG 8'h00
`define DEF_PORTS 8'h0F
`define DEF_ZERO 8'h00
// byte 17 / byte 18 bit positions
`define BIT_TOL 7
`define BIT_COMPOUND 6
`define BIT_FSONLY 5
`define BIT_NOIND 4
`define BIT_GANG 2
`define BIT_AMBER 7
`define BIT_GREEN 6
`define BIT_SELFCAP 5
`define BIT_MOD 4
`define BIT_PWRPOL 3
`define BIT_FLTPOL 2
`define BIT_FDIS 1
`define BIT_FPP 0
// codes
`define WP_CODE 8'h42
`define MAX_LANGS 8'h1F
`define HUB_DESC_TYPE 8'h29
`define ZERO_DESC_TYPE 8'h00
`define LOOK_KINDS 3'h6
// register byte offsets
`define R_STATUS 8'h00
`define R_CFG0 8'h04
`define R_CFG1 8'h08
`define R_CFG2 8'h0C
`define R_HUBDESC 8'h10
`define R_DEVDESC 8'h14
`define R_STRIDX 8'h18
`define R_LOOKUP 8'h1C
`define R_PORTCTL 8'h20
`define R_FAULT 8'h24
`define R_QUERY 8'h28
// timing
`define CLK_PERIOD_NS 100
`define MS_NS 1000000
`define MOD_HZ 120
`define S_NS 1000000000
`endif

// file: hdl/hub_cfg_pkg.sv
`default_nettype none
package hub_cfg_pkg;
  typedef enum logic [2:0] {
    ST_FETCH = 3'b001,
    ST_DONE = 3'b010,
    ST_LOOK = 3'b100
  } load_state_e;
  typedef struct packed {
    logic pend;
    logic [7:0] addr;
  } wr_phase_s;
  typedef struct packed {
    logic [2:0] kind;
    logic [4:0] lang;
  } lookup_s;
endpackage
`default_nettype wire

// file: hdl/hub_eeprom_config_decoder.sv
// Operation
// - filter byte splits into live/idle ms counts
// - upstream demand byte chosen by attach speed
// - controller current chosen by speed and supply
// - power-good delay reported in 2 ms units
// - zero descriptor type accepted only if tolerated
// - combined flag goes to characteristics bit 2
// - full-speed-only blocks high-speed attach
// - indicator disable darkens leds, clears bit 7
// - shared switching drives all usable ports, bits 3,1,0
// - four pin groups follow configured polarity
// - self power only when capable
// - leds gated by 120 Hz when pulse saving
// - fault mode disable, per port or summed
// - protection code locks later memory writes
// - languages 1..31 enable strings, else none
// - nonzero string index only when present
// - usable mask gives downstream port count
// - logical ports numbered skipping unusable ones
// - language codes start at image byte 24
// - six pointer arrays follow, each 2N apart
// - first byte marker selects this layout
`include "hub_cfg_map.svh"
`default_nettype none
module hub_eeprom_config_decoder
  import hub_cfg_pkg::*;
#(
  parameter int MS_CYCLES = `MS_NS / `CLK_PERIOD_NS,
  parameter int WAVE_HALF_CYCLES = `S_NS / (2 * `MOD_HZ * `CLK_PERIOD_NS)
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic mem_req,
  output logic [15:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [7:0] mem_data,
  input wire logic hs_attached,
  input wire logic self_supply_present,
  input wire logic [3:0] fault_pin,
  output logic [3:0] power_switch_pin,
  output logic [3:0] yellow_led_pin,
  output logic [3:0] go_led_pin,
  output logic config_done,
  output logic hs_permit,
  output logic memory_write_lock
);
  // refuse cycle counts the dividers cannot serve
  if (MS_CYCLES < 1 || WAVE_HALF_CYCLES < 1) begin : g_bad_counts
    $error("cycle counts must be at least one");
  end

  ////////////////////////////////////////////////////////////////////////////
  // image bytes, defaults until loaded
  logic [7:0] img_q [`B_FILTER:`B_DETACH];
  load_state_e state_q;
  logic bad_image_q;
  logic [15:0] look_res_q;
  logic look_err_q;
  logic look_hi_q;
  lookup_s look_q;

  function automatic logic [7:0] def_byte(input int i);
    case (i)
      `B_FILTER: def_byte = `DEF_FILTER;
      `B_FS_DEMAND: def_byte = `DEF_FS_DEMAND;
      `B_HS_DEMAND: def_byte = `DEF_HS_DEMAND;
      `B_CC_FSB, `B_CC_FSS: def_byte = `DEF_CC_FS;
      `B_CC_HSB: def_byte = `DEF_CC_HSB;
      `B_CC_HSS: def_byte = `DEF_CC_HSS;
      `B_PG_DELAY: def_byte = `DEF_PG_DELAY;
      `B_HUBCFG: def_byte = `DEF_HUBCFG;
      `B_USABLE, `B_DETACH: def_byte = `DEF_PORTS;
      default: def_byte = `DEF_ZERO;
    endcase
  endfunction

  // decoded fields
  logic [3:0] live_port_fault_filter_ms, idle_port_fault_filter_ms;
  logic [7:0] language_count, string_presence_mask;
  logic [3:0] usable_port_mask, detachable_port_mask;
  logic zero_type_request_tolerance, combined_device_flag, fs_only, indicator_disable;
  logic shared_power_switching, yellow_led_polarity, go_led_polarity;
  logic local_supply_capable, led_pulse_saving, switch_output_polarity;
  logic fault_input_polarity, fault_detect_disable, fault_report_per_port;
  assign {live_port_fault_filter_ms, idle_port_fault_filter_ms} = img_q[`B_FILTER];
  assign language_count = img_q[`B_LANGS];
  assign string_presence_mask = img_q[`B_STRMASK];
  assign usable_port_mask = img_q[`B_USABLE][3:0];
  assign detachable_port_mask = img_q[`B_DETACH][3:0];
  assign zero_type_request_tolerance = img_q[`B_HUBCFG][`BIT_TOL];
  assign combined_device_flag = img_q[`B_HUBCFG][`BIT_COMPOUND];
  assign fs_only = img_q[`B_HUBCFG][`BIT_FSONLY];
  assign indicator_disable = img_q[`B_HUBCFG][`BIT_NOIND];
  assign shared_power_switching = img_q[`B_HUBCFG][`BIT_GANG];
  assign yellow_led_polarity = img_q[`B_PINCFG][`BIT_AMBER];
  assign go_led_polarity = img_q[`B_PINCFG][`BIT_GREEN];
  assign local_supply_capable = img_q[`B_PINCFG][`BIT_SELFCAP];
  assign led_pulse_saving = img_q[`B_PINCFG][`BIT_MOD];
  assign switch_output_polarity = img_q[`B_PINCFG][`BIT_PWRPOL];
  assign fault_input_polarity = img_q[`B_PINCFG][`BIT_FLTPOL];
  assign fault_detect_disable = img_q[`B_PINCFG][`BIT_FDIS];
  assign fault_report_per_port = img_q[`B_PINCFG][`BIT_FPP];

  // derived descriptor values
  logic strings_en, hs_eff, self_eff;
  logic [7:0] upstream_current_demand, controller_current_draw, port_power_good_delay;
  logic [15:0] hub_char;
  logic [2:0] port_count;
  logic [7:0] removable_field, phys_of_log;
  logic [17:0] str_idx;
  assign strings_en = (language_count != `DEF_ZERO) && (language_count <= `MAX_LANGS);
  assign hs_eff = hs_attached && !fs_only;
  assign self_eff = self_supply_present && local_supply_capable;
  assign upstream_current_demand = hs_eff ? img_q[`B_HS_DEMAND] : img_q[`B_FS_DEMAND];
  assign port_power_good_delay = img_q[`B_PG_DELAY];

  // controller current by speed and supply
  always_comb begin
    case ({self_eff, hs_eff})
      2'b00: controller_current_draw = img_q[`B_CC_FSB];
      2'b01: controller_current_draw = img_q[`B_CC_HSB];
      2'b10: controller_current_draw = img_q[`B_CC_FSS];
      default: controller_current_draw = img_q[`B_CC_HSS];
    endcase
  end

  // hub characteristics word
  always_comb begin
    hub_char = 16'h0000;
    hub_char[1:0] = shared_power_switching ? 2'b00 : 2'b01;
    hub_char[2] = combined_device_flag;
    hub_char[4] = fault_detect_disable;
    hub_char[3] = fault_report_per_port && !shared_power_switching;
    hub_char[7] = !indicator_disable;
  end

  // port count, logical numbering, removable field
  always_comb begin
    logic [2:0] n;
    logic [3:0] rem;
    n = 3'd0;
    rem = 4'h0;
    phys_of_log = 8'h00;
    for (int p = 0; p < 4; p++) begin
      if (usable_port_mask[p]) begin
        phys_of_log[2*n +: 2] = p[1:0];
        rem[n[1:0]] = detachable_port_mask[n[1:0]];
        n = n + 3'd1;
      end
    end
    port_count = n;
    removable_field = {3'b000, rem, 1'b0};
  end

  // string indices
  always_comb begin
    str_idx = 18'h00000;
    for (int k = 0; k < 6; k++) begin
      if (strings_en && string_presence_mask[k]) str_idx[3*k +: 3] = 3'(k + 1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // image fetch and pointer lookup engine
  logic look_start;
  lookup_s look_in;
  logic [15:0] look_addr;
  logic look_ok;
  assign look_addr = `LANG_BASE + 16'({look_q.kind, 1'b0}) * 16'(language_count)
      + 16'({look_q.lang, 1'b0}) + 16'(look_hi_q);
  assign look_ok = strings_en && (look_in.kind <= `LOOK_KINDS)
      && (8'(look_in.lang) < language_count);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = `B_FILTER; i <= `B_DETACH; i++) img_q[i] <= def_byte(i);
      state_q <= ST_FETCH;
      mem_req <= 1'b0;
      mem_addr <= 16'h0000;
      bad_image_q <= 1'b0;
      look_q <= '0;
      look_hi_q <= 1'b0;
      look_res_q <= 16'h0000;
      look_err_q <= 1'b0;
    end else begin
      case (state_q)
        ST_FETCH: begin
          if (!mem_req) begin
            mem_req <= 1'b1;
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            if (mem_addr == `B_MARK) begin
              if (mem_data != `IMG_MARKER) begin
                bad_image_q <= 1'b1;
                state_q <= ST_DONE;
              end
              mem_addr <= `B_FIRST;
            end else begin
              img_q[5'(mem_addr)] <= mem_data;
              if (mem_addr == `B_LAST) state_q <= ST_DONE;
              mem_addr <= mem_addr + 16'h0001;
            end
          end
        end
        ST_DONE: begin
          if (look_start) begin
            look_q <= look_in;
            look_hi_q <= 1'b0;
            look_err_q <= !look_ok;
            look_res_q <= 16'h0000;
            if (look_ok) state_q <= ST_LOOK;
          end
        end
        ST_LOOK: begin
          if (!mem_req) begin
            mem_req <= 1'b1;
            mem_addr <= look_addr;
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            look_hi_q <= 1'b1;
            if (look_hi_q) begin
              look_res_q[15:8] <= mem_data;
              state_q <= ST_DONE;
            end else begin
              look_res_q[7:0] <= mem_data;
            end
          end
        end
        default: state_q <= ST_DONE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait states
  wr_phase_s wr_q;
  logic [3:0] pwr_req_q, yellow_req_q, go_req_q;
  logic [7:0] query_q;
  logic [3:0] fault_q;
  logic addr_ok;
  logic [31:0] rd_val;
  assign addr_ok = hsel && htrans[1] && hready && (hsize == 3'b010);
  assign look_start = wr_q.pend && (wr_q.addr == `R_LOOKUP);
  assign look_in = lookup_s'({hwdata[10:8], hwdata[4:0]});

  // read mux
  always_comb begin
    case (haddr[7:0])
      `R_STATUS: rd_val = {22'h0, look_err_q, bad_image_q, state_q == ST_DONE,
          strings_en, port_count, hs_eff, self_eff, state_q == ST_LOOK};
      `R_CFG0: rd_val = {img_q[`B_FILTER], img_q[`B_FS_DEMAND], img_q[`B_HS_DEMAND],
          img_q[`B_PG_DELAY]};
      `R_CFG1: rd_val = {img_q[`B_HUBCFG], img_q[`B_PINCFG], img_q[`B_WPROT],
          img_q[`B_LANGS]};
      `R_CFG2: rd_val = {img_q[`B_STRMASK], img_q[`B_USABLE], img_q[`B_DETACH], 8'h00};
      `R_HUBDESC: rd_val = {port_power_good_delay, controller_current_draw, hub_char};
      `R_DEVDESC: rd_val = {upstream_current_demand, removable_field, phys_of_log,
          5'h00, port_count};
      `R_STRIDX: rd_val = {14'h0, str_idx};
      `R_LOOKUP: rd_val = {state_q == ST_LOOK, 15'h0, look_res_q};
      `R_PORTCTL: rd_val = {20'h0, yellow_req_q, go_req_q, pwr_req_q};
      `R_FAULT: rd_val = {28'h0, fault_q};
      `R_QUERY: rd_val = {23'h0, (query_q == `HUB_DESC_TYPE)
          || (query_q == `ZERO_DESC_TYPE && zero_type_request_tolerance), query_q};
      default: rd_val = 32'h00000000;
    endcase
  end

  // address phase capture and read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= '0;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_q.pend <= addr_ok && hwrite;
      wr_q.addr <= haddr[7:0];
      if (addr_ok && !hwrite) hrdata <= rd_val;
    end
  end

  // writable registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwr_req_q <= 4'h0;
      yellow_req_q <= 4'h0;
      go_req_q <= 4'h0;
      query_q <= `HUB_DESC_TYPE;
    end else if (wr_q.pend) begin
      if (wr_q.addr == `R_PORTCTL) begin
        pwr_req_q <= hwdata[3:0];
        go_req_q <= hwdata[7:4];
        yellow_req_q <= hwdata[11:8];
      end
      if (wr_q.addr == `R_QUERY) query_q <= hwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ms tick and indicator square wave
  logic [$clog2(MS_CYCLES+1)-1:0] ms_cnt_q;
  logic [$clog2(WAVE_HALF_CYCLES+1)-1:0] wave_cnt_q;
  logic ms_tick_q, wave_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ms_cnt_q <= '0;
      ms_tick_q <= 1'b0;
    end else begin
      ms_tick_q <= (ms_cnt_q == $bits(ms_cnt_q)'(MS_CYCLES - 1));
      // wrap on the count itself so one tick spans exactly MS_CYCLES
      if (ms_cnt_q == $bits(ms_cnt_q)'(MS_CYCLES - 1)) begin
        ms_cnt_q <= '0;
      end else begin
        ms_cnt_q <= ms_cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wave_cnt_q <= '0;
      wave_q <= 1'b0;
    end else if (wave_cnt_q == $bits(wave_cnt_q)'(WAVE_HALF_CYCLES - 1)) begin
      wave_cnt_q <= '0;
      wave_q <= !wave_q;
    end else begin
      wave_cnt_q <= wave_cnt_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fault inputs: sync, polarity, mode, filter
  logic [3:0] fsync1_q, fsync2_q, fault_act, port_on;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fsync1_q <= 4'h0;
      fsync2_q <= 4'h0;
    end else begin
      fsync1_q <= fault_pin;
      fsync2_q <= fsync1_q;
    end
  end

  assign fault_act = fault_input_polarity ? fsync2_q : ~fsync2_q;
  assign port_on = (shared_power_switching ? {4{|pwr_req_q}} : pwr_req_q)
      & usable_port_mask & {4{state_q != ST_FETCH}};

  for (genvar i = 0; i < 4; i++) begin : g_flt
    logic [3:0] cnt_q;
    logic src;
    logic [3:0] lim;
    assign src = !fault_detect_disable
        && (fault_report_per_port ? fault_act[i] : |(fault_act & usable_port_mask));
    assign lim = port_on[i] ? live_port_fault_filter_ms : idle_port_fault_filter_ms;
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        cnt_q <= 4'h0;
        fault_q[i] <= 1'b0;
      end else if (!src) begin
        cnt_q <= 4'h0;
        fault_q[i] <= 1'b0;
      end else if (cnt_q >= lim) begin
        fault_q[i] <= 1'b1;
      end else if (ms_tick_q) begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output pins and status flops
  logic led_gate;
  assign led_gate = !indicator_disable && (state_q != ST_FETCH)
      && (!led_pulse_saving || wave_q);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      power_switch_pin <= 4'hF;
      yellow_led_pin <= 4'hF;
      go_led_pin <= 4'hF;
      config_done <= 1'b0;
      hs_permit <= 1'b0;
      memory_write_lock <= 1'b0;
    end else begin
      power_switch_pin <= switch_output_polarity ? port_on : ~port_on;
      yellow_led_pin <= yellow_led_polarity ? (yellow_req_q & {4{led_gate}})
          : ~(yellow_req_q & {4{led_gate}});
      go_led_pin <= go_led_polarity ? (go_req_q & {4{led_gate}})
          : ~(go_req_q & {4{led_gate}});
      config_done <= (state_q != ST_FETCH);
      hs_permit <= (state_q != ST_FETCH) && !fs_only;
      memory_write_lock <= (img_q[`B_WPROT] == `WP_CODE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_fs_only;
    fs_only && state_q != ST_FETCH |=> !hs_permit;
  endproperty
  a_fs_only: assert property (p_fs_only) else $error("high speed permitted");

  property p_lock;
    img_q[`B_WPROT] == `WP_CODE |=> memory_write_lock;
  endproperty
  a_lock: assert property (p_lock) else $error("write lock missing");

  property p_no_power_early;
    state_q == ST_FETCH
        |=> power_switch_pin == ($past(switch_output_polarity) ? 4'h0 : 4'hF);
  endproperty
  a_no_power_early: assert property (p_no_power_early) else $error("power before load");

  property p_ind_off;
    indicator_disable |=> $stable(indicator_disable) |-> !led_gate && hub_char[7] == 1'b0;
  endproperty
  a_ind_off: assert property (p_ind_off) else $error("indicator not off");

  property p_fault_off;
    fault_detect_disable [*2] |-> fault_q == 4'h0;
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("fault while disabled");

  property p_marker;
    state_q == ST_FETCH && mem_req && mem_ack && mem_addr == `B_MARK
        && mem_data != `IMG_MARKER |=> bad_image_q ##1 config_done;
  endproperty
  a_marker: assert property (p_marker) else $error("bad marker accepted");

  property p_count;
    port_count == 3'($countones(usable_port_mask));
  endproperty
  a_count: assert property (p_count) else $error("port count wrong");

  property p_strings;
    language_count > `MAX_LANGS || language_count == 8'h00 |-> str_idx == 18'h0 && !strings_en;
  endproperty
  a_strings: assert property (p_strings) else $error("strings not disabled");

  property p_wave;
    $changed(wave_q) |=> !$changed(wave_q);
  endproperty
  a_wave: assert property (p_wave) else $error("wave toggled twice");

  property p_demand;
    hs_attached && !fs_only |-> upstream_current_demand == img_q[`B_HS_DEMAND];
  endproperty
  a_demand: assert property (p_demand) else $error("demand byte wrong");

  c_load: cover property (state_q == ST_FETCH ##1 state_q == ST_DONE && !bad_image_q);
  c_look: cover property (state_q == ST_LOOK ##[1:20] state_q == ST_DONE);
  c_fault: cover property ($rose(fault_q[0]));
endmodule
`default_nettype wire

// file: testbench/eeprom_image_model.sv
`default_nettype none
module eeprom_image_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic mem_req,
  input wire logic [15:0] mem_addr,
  input wire logic [3:0] delay,
  output logic mem_ack,
  output logic [7:0] mem_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] img [0:63];
  logic [3:0] wait_q;
  // answer a held request after the chosen delay with a one-cycle ack
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_ack <= 1'b0;
      wait_q <= 4'h0;
      mem_data <= 8'hA5;
    end else if (mem_req && !mem_ack && wait_q >= delay) begin
      mem_ack <= 1'b1;
      wait_q <= 4'h0;
      mem_data <= img[mem_addr[5:0]];
    end else begin
      mem_ack <= 1'b0;
      wait_q <= (mem_req && !mem_ack) ? wait_q + 4'h1 : 4'h0;
      mem_data <= ~mem_data; // data not valid outside ack
    end
  end
endmodule
`default_nettype wire

// file: testbench/hub_eeprom_config_decoder_tb_top.sv
`include "hub_cfg_map.svh"
`default_nettype none
module hub_eeprom_config_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk, hresetn, hsel, hwrite, hs_attached, self_supply_present;
  logic hreadyout, hresp, mem_req, mem_ack, config_done, hs_permit, memory_write_lock;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] fault_pin, power_switch_pin, yellow_led_pin, go_led_pin, delay;
  logic [15:0] mem_addr;
  logic [7:0] mem_data;
  int mismatches, n_compared, n_hi;
  localparam logic [135:0] GOOD = 136'h5A_11_22_00_00_01_02_03_04_19_44_2E_42_02_05_0A_01;
  ////////////////////////////////////////////////////////////////
  hub_eeprom_config_decoder #(.MS_CYCLES(10), .WAVE_HALF_CYCLES(20)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_data(mem_data),
    .hs_attached(hs_attached), .self_supply_present(self_supply_present),
    .fault_pin(fault_pin), .power_switch_pin(power_switch_pin),
    .yellow_led_pin(yellow_led_pin), .go_led_pin(go_led_pin),
    .config_done(config_done), .hs_permit(hs_permit),
    .memory_write_lock(memory_write_lock));
  eeprom_image_model mem_u (.hclk(hclk), .hresetn(hresetn), .mem_req(mem_req),
    .mem_addr(mem_addr), .delay(delay), .mem_ack(mem_ack), .mem_data(mem_data));
  // 10 MHz clock
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("mismatches %0d compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // one edge at which hready is seen high, bounded
  task automatic ready_edge();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    if (hreadyout !== 1'b1) begin
      mismatches++;
      end_of_test();
    end
  endtask
  // single word transfer: address phase, then data phase
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    ready_edge();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    ready_edge();
    rd = hrdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h00000000);
    chk(rd, exp);
    chk({hresp, hreadyout}, 32'h1);
  endtask
  // reset, then wait for the image load to finish
  task automatic boot(input logic [3:0] d);
    int n;
    delay <= d;
    hresetn <= 1'b0;
    repeat (5) @(posedge hclk);
    chk({config_done, power_switch_pin}, 32'h0F);
    hresetn <= 1'b1;
    n = 0;
    while (config_done !== 1'b1 && n < 3000) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 3000) begin
      mismatches++;
      end_of_test();
    end
  endtask
  // start a lookup and poll until it is no longer busy
  task automatic lookup(input logic [31:0] req, input logic [31:0] exp);
    int n;
    ahb(1'b1, `R_LOOKUP, req);
    n = 0;
    do begin
      ahb(1'b0, `R_LOOKUP, 32'h00000000);
      n++;
    end while (rd[31] !== 1'b0 && n < 50);
    if (rd[31] !== 1'b0) begin
      mismatches++;
      end_of_test();
    end
    chk({16'h0000, rd[15:0]}, exp);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    hs_attached = 1'b0;
    self_supply_present = 1'b0;
    fault_pin = 4'hF;
    delay = 4'h0;
    mismatches = 0;
    n_compared = 0;
    for (int i = 0; i < 64; i++) mem_u.img[i] = 8'h00;
    // wrong marker: load stops, defaults stay
    boot(4'h0);
    rdchk(`R_CFG0, 32'h88285732);
    rdchk(`R_CFG1, 32'h80000000);
    rdchk(`R_CFG2, 32'h000F0F00);
    rdchk(`R_STATUS, 32'h000001A0);
    chk({hs_permit, memory_write_lock}, 32'h2);
    rdchk(8'h40, 32'h00000000);
    ahb(1'b1, `R_QUERY, 32'h00000000);
    rdchk(`R_QUERY, 32'h00000100);
    fault_pin <= 4'hE;
    repeat (70) @(posedge hclk);
    rdchk(`R_FAULT, 32'h00000000);
    repeat (40) @(posedge hclk);
    rdchk(`R_FAULT, 32'h0000000F);
    // proper image, slow memory
    fault_pin <= 4'h0;
    mem_u.img[0] = `IMG_MARKER;
    for (int i = 0; i < 17; i++) mem_u.img[7 + i] = GOOD[8 * (16 - i) +: 8];
    mem_u.img[26] = 8'h34;
    mem_u.img[27] = 8'h12;
    mem_u.img[30] = 8'h28;
    mem_u.img[31] = 8'h00;
    mem_u.img[40] = 8'h04;
    mem_u.img[41] = 8'h03;
    boot(4'h3);
    rdchk(`R_CFG0, 32'h5A112219);
    rdchk(`R_CFG1, 32'h442E4202);
    rdchk(`R_CFG2, 32'h050A0100);
    chk({hs_permit, memory_write_lock}, 32'h3);
    rdchk(`R_STRIDX, 32'h000000C1);
    for (int s = 0; s < 4; s++) begin
      hs_attached <= s[1];
      self_supply_present <= s[0];
      repeat (2) @(posedge hclk);
      ahb(1'b0, `R_HUBDESC, 32'h00000000);
      chk(rd[23:16], s[1] ? (s[0] ? 32'h4 : 32'h2) : (s[0] ? 32'h3 : 32'h1));
      chk({rd[31:24], rd[7], rd[4:0]}, {8'h19, 1'b1, 5'b10100});
      ahb(1'b0, `R_DEVDESC, 32'h00000000);
      chk(rd[31:24], s[1] ? 32'h22 : 32'h11);
      chk(rd[23:0], 32'h020D02);
      ahb(1'b0, `R_STATUS, 32'h00000000);
      chk(rd[5:1], {3'd2, s[1], s[0]});
    end
    lookup(32'h00000101, 32'h00000028);
    lookup(32'h00000001, 32'h00001234);
    ahb(1'b1, `R_PORTCTL, 32'h00000121);
    repeat (2) @(posedge hclk);
    chk({power_switch_pin, yellow_led_pin, go_led_pin}, 32'hAED);
    fault_pin <= 4'hF;
    repeat (120) @(posedge hclk);
    rdchk(`R_FAULT, 32'h00000000);
    ahb(1'b1, `R_QUERY, 32'h00000000);
    rdchk(`R_QUERY, 32'h00000000);
    ahb(1'b1, `R_QUERY, 32'h00000029);
    rdchk(`R_QUERY, 32'h00000129);
    // full speed only, per-port power, modulated indicators
    mem_u.img[17] = 8'h20;
    mem_u.img[18] = 8'hD9;
    boot(4'h0);
    chk({hs_permit, memory_write_lock}, 32'h1);
    ahb(1'b0, `R_DEVDESC, 32'h00000000);
    chk(rd[31:24], 32'h11);
    ahb(1'b0, `R_HUBDESC, 32'h00000000);
    chk(rd[7:0], 32'h89);
    ahb(1'b1, `R_PORTCTL, 32'h00000F2F);
    repeat (2) @(posedge hclk);
    chk(power_switch_pin, 32'hA);
    n_hi = 0;
    repeat (40) begin
      @(posedge hclk);
      if ({yellow_led_pin, go_led_pin} == 8'hF2) begin
        n_hi++;
      end else begin
        chk({yellow_led_pin, go_led_pin}, 32'h00);
      end
    end
    chk(n_hi, 20);
    // indicators disabled
    mem_u.img[17] = 8'h10;
    boot(4'h0);
    ahb(1'b1, `R_PORTCTL, 32'h00000FF0);
    repeat (2) @(posedge hclk);
    chk({power_switch_pin, yellow_led_pin, go_led_pin}, 32'h000);
    ahb(1'b0, `R_HUBDESC, 32'h00000000);
    chk(rd[7:0], 32'h09);
    end_of_test();
  end
endmodule
`default_nettype wire
